// ---- hw/cmcp_pkg.sv ----
/*
 * Constants for the CAN mode control and prescaler block: register
 * offsets, field positions, reset values and timing figures.
 * Assumes a 100 MHz system clock and an AXI4-Lite register bus.
 */
package cmcp_pkg;
    localparam logic [5:0] ADDR_CTL_ZERO = 6'h00;
    localparam logic [5:0] ADDR_CTL_ONE = 6'h04;
    localparam logic [5:0] ADDR_BTR_ZERO = 6'h08;
    localparam logic [5:0] ADDR_STATUS = 6'h0C;
    // Control zero fields
    localparam int C0_INIT_REQUEST = 0;
    localparam int C0_SLEEP_REQUEST = 1;
    localparam int C0_WAKE_ENABLE = 2;
    // Control one fields
    localparam int C1_INIT_ACKNOWLEDGE = 0;
    localparam int C1_SLEEP_ACKNOWLEDGE = 1;
    localparam int C1_WFILT = 2;
    localparam int C1_BORSEL = 3;
    localparam int C1_LISTEN = 4;
    localparam int C1_LOOP = 5;
    localparam int C1_CLKSEL = 6;
    localparam int C1_ENABLE = 7;
    localparam logic [7:0] CTL_ONE_RESET = 8'h01;
    localparam logic [7:0] CTL_ZERO_RESET = 8'h01;
    localparam logic [7:0] BTR_ZERO_RESET = 8'h00;
    localparam logic [7:0] CTL_ONE_WMASK = 8'hFC;
    localparam int BTR_SJW_HI = 7;
    localparam int BTR_SJW_LO = 6;
    localparam int BTR_BRP_HI = 5;
    // Wake filter minimum pulse time in ns
    localparam int WAKE_PULSE_MIN_NS = 2000;
    localparam int CLK_PERIOD_NS = 10;
    localparam int WAKE_PULSE_CYC =
        (WAKE_PULSE_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam logic [1:0] RESP_OKAY = 2'b00;
    localparam logic [1:0] RESP_SLVERR = 2'b10;
    typedef enum logic [2:0] {
        CMCP_RUN = 3'b001,
        CMCP_INIT = 3'b010,
        CMCP_SLEEP = 3'b100
    } cmcp_mode_t;
endpackage : cmcp_pkg

// ---- hw/cmcp_top.sv ----
/*
 * CAN mode control and prescaler: control/handshake registers, first
 * bit-timing register, mode state machine, wake filter and quantum divider.
 * Assumes all inputs synchronous to ref_clk; protocol engine lies outside.
 */
// Local design decisions: the AXI4-Lite register port and the register addresses.
// Overview of operation
// - Control one readable always; writable only while init request and ack set.
// - Enable bit writes once in normal operation; special mode any in init.
// - Enable bit zero disables controller, one enables it.
// - Clock select zero picks oscillator clock, one picks bus clock.
// - Loopback bit routes transmitter stream back into own receiver.
// - Listen mode receives matching frames, never drives ack or error frames.
// - Listen mode freezes transmit and receive error counters.
// - Listen mode transmits no messages whatever buffers are pending.
// - Bus-off recovery select: zero automatic, one only on user request.
// - Wake filter zero wakes on any dominant; one needs minimum pulse.
// - Sleep ack set on sleep entry; sleep active when request and ack.
// - With wake enabled, bus activity in sleep clears sleep ack.
// - Clearing sleep request also clears sleep ack.
// - Init ack reports init mode; active when request and ack set.
// - Control one and timing registers written only in init mode.
// - Timing zero readable always; writes only in init mode.
// - Jump-width codes 0 to 3 select 1 to 4 quanta.
// - Prescaler value is field plus one, 1 to 64.
// - Init request enters init, aborts transfer, loses bus sync.
// - Sleep request serviced only when bus idle.
// - Wake enable lets bus traffic end sleep; otherwise ignored.
`timescale 1ns/100ps
module cmcp_top (
    input wire logic ref_clk,
    input wire logic nrst,
    input wire logic specialMode,
    input wire logic oscClkTick,
    input wire logic busIdle,
    input wire logic busRx,
    input wire logic busOffState,
    input wire logic userRecoverReq,
    input wire logic txBitIn,
    input wire logic [5:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [5:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    output logic moduleEnable,
    output logic tqTick,
    output logic [2:0] resyncJumpQuanta,
    output logic loopRxBit,
    output logic ackErrDriveEn,
    output logic errCntFreeze,
    output logic txInhibit,
    output logic recoverAllowed,
    output logic protoAbort,
    output logic wakeEvent
);
    import cmcp_pkg::*;

    logic [7:0] ctlZero_reg;
    logic [7:0] ctlOne_reg;
    logic [7:0] btrZero_reg;
    logic enableWritten_reg;
    cmcp_mode_t mode_reg;
    logic [15:0] wakeCnt_reg;
    logic [5:0] divCnt_reg;
    logic awHeld_reg;
    logic wHeld_reg;
    logic [5:0] awAddr_reg;
    logic [31:0] wData_reg;
    logic [3:0] wStrb_reg;

    function automatic logic initActive(input logic [7:0] c0,
                                        input logic [7:0] c1);
        initActive = c0[C0_INIT_REQUEST] & c1[C1_INIT_ACKNOWLEDGE];
    endfunction : initActive

    logic inInit;
    logic doWrite;
    logic lane0;
    logic srcTick;
    logic dominant;
    logic wakeHit;
    assign inInit = initActive(ctlZero_reg, ctlOne_reg);
    assign doWrite = awHeld_reg & wHeld_reg & ~s_axi_bvalid;
    assign lane0 = wStrb_reg[0];
    assign dominant = ~busRx;
    // Bus clock ticks every cycle; oscillator arrives as an enable pulse
    assign srcTick = ctlOne_reg[C1_CLKSEL] ? 1'b1 : oscClkTick;
    assign wakeHit = ctlOne_reg[C1_WFILT]
        ? (wakeCnt_reg >= 16'(WAKE_PULSE_CYC)) : dominant;

    // Write channel capture, address and data in either order
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            awHeld_reg <= 1'b0;
            wHeld_reg <= 1'b0;
            awAddr_reg <= 6'h00;
            wData_reg <= 32'h0000_0000;
            wStrb_reg <= 4'h0;
        end else if (doWrite) begin
            awHeld_reg <= 1'b0;
            wHeld_reg <= 1'b0;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                awHeld_reg <= 1'b1;
                awAddr_reg <= s_axi_awaddr;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                wHeld_reg <= 1'b1;
                wData_reg <= s_axi_wdata;
                wStrb_reg <= s_axi_wstrb;
            end
        end
    end

    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            s_axi_awready <= 1'b0;
            s_axi_wready <= 1'b0;
        end else begin
            s_axi_awready <= ~awHeld_reg & ~s_axi_awready & ~s_axi_bvalid
                & s_axi_awvalid;
            s_axi_wready <= ~wHeld_reg & ~s_axi_wready & ~s_axi_bvalid
                & s_axi_wvalid;
        end
    end

    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= RESP_OKAY;
        end else if (doWrite) begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= (awAddr_reg == ADDR_CTL_ZERO ||
                awAddr_reg == ADDR_CTL_ONE || awAddr_reg == ADDR_BTR_ZERO
                || awAddr_reg == ADDR_STATUS) ? RESP_OKAY : RESP_SLVERR;
        end else if (s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
        end
    end

    // Read channel; one cycle from address accept to data
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h0000_0000;
            s_axi_rresp <= RESP_OKAY;
        end else begin
            s_axi_arready <= s_axi_arvalid & ~s_axi_arready & ~s_axi_rvalid;
            if (s_axi_arvalid && s_axi_arready) begin
                s_axi_rvalid <= 1'b1;
                s_axi_rresp <= RESP_OKAY;
                case (s_axi_araddr)
                    ADDR_CTL_ZERO: s_axi_rdata <= {24'h000000, ctlZero_reg};
                    ADDR_CTL_ONE: s_axi_rdata <= {24'h000000, ctlOne_reg};
                    ADDR_BTR_ZERO: s_axi_rdata <= {24'h000000, btrZero_reg};
                    ADDR_STATUS: s_axi_rdata <= {29'h0, mode_reg};
                    default: begin
                        s_axi_rdata <= 32'h0000_0000;
                        s_axi_rresp <= RESP_SLVERR;
                    end
                endcase
            end else if (s_axi_rready) begin
                s_axi_rvalid <= 1'b0;
            end
        end
    end

    // Control zero: software requests; hardware clears sleep request on wake
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            ctlZero_reg <= CTL_ZERO_RESET;
        end else begin
            if (doWrite && lane0 && awAddr_reg == ADDR_CTL_ZERO) begin
                ctlZero_reg <= {5'h00, wData_reg[C0_WAKE_ENABLE],
                    wData_reg[C0_SLEEP_REQUEST], wData_reg[C0_INIT_REQUEST]};
                // Request cannot be dropped before its ack arrives
                if (ctlZero_reg[C0_INIT_REQUEST] && !ctlOne_reg[C1_INIT_ACKNOWLEDGE])
                    ctlZero_reg[C0_INIT_REQUEST] <= 1'b1;
                if (ctlZero_reg[C0_SLEEP_REQUEST] && !ctlOne_reg[C1_SLEEP_ACKNOWLEDGE])
                    ctlZero_reg[C0_SLEEP_REQUEST] <= 1'b1;
            end
            if (mode_reg == CMCP_SLEEP && ctlZero_reg[C0_WAKE_ENABLE] && wakeHit)
                ctlZero_reg[C0_SLEEP_REQUEST] <= 1'b0;
        end
    end

    // Mode machine drives both acknowledge flags
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            mode_reg <= CMCP_INIT;
        end else begin
            case (mode_reg)
                CMCP_RUN: begin
                    if (ctlZero_reg[C0_INIT_REQUEST])
                        mode_reg <= CMCP_INIT;
                    else if (ctlZero_reg[C0_SLEEP_REQUEST] && busIdle)
                        mode_reg <= CMCP_SLEEP;
                end
                CMCP_INIT: begin
                    if (!ctlZero_reg[C0_INIT_REQUEST])
                        mode_reg <= CMCP_RUN;
                end
                CMCP_SLEEP: begin
                    if (ctlZero_reg[C0_INIT_REQUEST])
                        mode_reg <= CMCP_INIT;
                    else if (!ctlZero_reg[C0_SLEEP_REQUEST])
                        mode_reg <= CMCP_RUN;
                    else if (ctlZero_reg[C0_WAKE_ENABLE] && wakeHit)
                        mode_reg <= CMCP_RUN;
                end
                default: mode_reg <= CMCP_INIT;
            endcase
        end
    end

    // Control one: writable fields plus hardware-owned ack bits
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            ctlOne_reg <= CTL_ONE_RESET;
            enableWritten_reg <= 1'b0;
        end else begin
            if (doWrite && lane0 && awAddr_reg == ADDR_CTL_ONE
                && inInit) begin
                ctlOne_reg[C1_ENABLE - 1:C1_WFILT] <=
                    wData_reg[C1_ENABLE - 1:C1_WFILT];
                if (specialMode || !enableWritten_reg) begin
                    ctlOne_reg[C1_ENABLE] <= wData_reg[C1_ENABLE];
                    enableWritten_reg <= 1'b1;
                end
            end
            ctlOne_reg[C1_INIT_ACKNOWLEDGE] <= (mode_reg == CMCP_INIT);
            ctlOne_reg[C1_SLEEP_ACKNOWLEDGE] <= (mode_reg == CMCP_SLEEP);
        end
    end

    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            btrZero_reg <= BTR_ZERO_RESET;
        end else if (doWrite && lane0 && awAddr_reg == ADDR_BTR_ZERO
                     && inInit) begin
            btrZero_reg <= wData_reg[7:0];
        end
    end

    // Dominant pulse length, counted in system cycles
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            wakeCnt_reg <= 16'h0000;
        end else if (!dominant || mode_reg != CMCP_SLEEP) begin
            wakeCnt_reg <= 16'h0000;
        end else if (wakeCnt_reg != 16'hFFFF) begin
            wakeCnt_reg <= wakeCnt_reg + 16'h0001;
        end
    end

    // Divider restarts in init so the quantum loses its phase
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            divCnt_reg <= 6'h00;
            tqTick <= 1'b0;
        end else if (!moduleEnable || mode_reg != CMCP_RUN) begin
            divCnt_reg <= 6'h00;
            tqTick <= 1'b0;
        end else if (srcTick) begin
            if (divCnt_reg >= btrZero_reg[BTR_BRP_HI:0]) begin
                divCnt_reg <= 6'h00;
                tqTick <= 1'b1;
            end else begin
                divCnt_reg <= divCnt_reg + 6'h01;
                tqTick <= 1'b0;
            end
        end else begin
            tqTick <= 1'b0;
        end
    end

    // Control outputs to the protocol engine
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            moduleEnable <= 1'b0;
            resyncJumpQuanta <= 3'h1;
            loopRxBit <= 1'b1;
            ackErrDriveEn <= 1'b0;
            errCntFreeze <= 1'b0;
            txInhibit <= 1'b1;
            recoverAllowed <= 1'b0;
            protoAbort <= 1'b1;
            wakeEvent <= 1'b0;
        end else begin
            moduleEnable <= ctlOne_reg[C1_ENABLE];
            resyncJumpQuanta <= {1'b0, btrZero_reg[BTR_SJW_HI:BTR_SJW_LO]}
                + 3'h1;
            // Loopback feeds the receiver from the transmitter, else the bus
            loopRxBit <= ctlOne_reg[C1_LOOP] ? txBitIn : busRx;
            ackErrDriveEn <= ~ctlOne_reg[C1_LISTEN];
            errCntFreeze <= ctlOne_reg[C1_LISTEN];
            txInhibit <= ctlOne_reg[C1_LISTEN] | ctlZero_reg[C0_INIT_REQUEST]
                | ~ctlOne_reg[C1_ENABLE];
            recoverAllowed <= busOffState & (~ctlOne_reg[C1_BORSEL]
                | userRecoverReq);
            protoAbort <= ctlZero_reg[C0_INIT_REQUEST];
            wakeEvent <= (mode_reg == CMCP_SLEEP) & ctlZero_reg[C0_WAKE_ENABLE]
                & wakeHit;
        end
    end

    // Ack bits trail the mode by one cycle, so handshakes span two steps
    sequence s_sleep_released;
        mode_reg == CMCP_SLEEP && !ctlZero_reg[C0_SLEEP_REQUEST];
    endsequence
    sequence s_init_acked;
        ##[1:3] ctlOne_reg[C1_INIT_ACKNOWLEDGE];
    endsequence

    a_ctl_write_lock: assert property (
        @(posedge ref_clk) disable iff (!nrst)
        !inInit |=> $stable(ctlOne_reg[C1_ENABLE:C1_WFILT]))
        else $error("control one changed outside init");
    a_btr_write_lock: assert property (
        @(posedge ref_clk) disable iff (!nrst)
        !inInit |=> $stable(btrZero_reg))
        else $error("timing zero changed outside init");
    a_listen_quiet: assert property (
        @(posedge ref_clk) disable iff (!nrst)
        ctlOne_reg[C1_LISTEN]
        |=> !ackErrDriveEn && txInhibit && errCntFreeze)
        else $error("listen mode not quiet");
    a_sleep_ack_set: assert property (
        @(posedge ref_clk) disable iff (!nrst)
        mode_reg == CMCP_SLEEP |=> ctlOne_reg[C1_SLEEP_ACKNOWLEDGE])
        else $error("sleep ack missing");
    a_sleep_idle: assert property (
        @(posedge ref_clk) disable iff (!nrst)
        mode_reg == CMCP_RUN && !busIdle |=> mode_reg != CMCP_SLEEP)
        else $error("sleep entered while busy");
    a_sleep_drop: assert property (
        @(posedge ref_clk) disable iff (!nrst)
        s_sleep_released |=> ##1 !ctlOne_reg[C1_SLEEP_ACKNOWLEDGE])
        else $error("sleep ack kept after request cleared");
    a_init_enter: assert property (
        @(posedge ref_clk) disable iff (!nrst)
        ctlZero_reg[C0_INIT_REQUEST] |-> s_init_acked)
        else $error("init ack late");
    a_sjw_map: assert property (
        @(posedge ref_clk) disable iff (!nrst)
        1'b1 |=> resyncJumpQuanta
            == $past(btrZero_reg[BTR_SJW_HI:BTR_SJW_LO]) + 3'h1)
        else $error("jump width wrong");
    a_tick_spacing: assert property (
        @(posedge ref_clk) disable iff (!nrst)
        tqTick && btrZero_reg[BTR_BRP_HI:0] != 6'h00
        && $stable(btrZero_reg) |=> !tqTick)
        else $error("quantum ticks too close");
    a_wake_filter: assert property (
        @(posedge ref_clk) disable iff (!nrst)
        mode_reg == CMCP_SLEEP && ctlOne_reg[C1_WFILT]
        && ctlZero_reg[C0_SLEEP_REQUEST] && !ctlZero_reg[C0_INIT_REQUEST]
        && wakeCnt_reg < 16'(WAKE_PULSE_CYC) |=> mode_reg == CMCP_SLEEP)
        else $error("filtered wake before minimum pulse");
endmodule : cmcp_top

// ---- bench/cmcp_bus_model.sv ----
/*
 * Behavioural far side: bus through a transceiver, recessive when idle.
 * Assumes commands from the bench arrive just after rising ref_clk edges.
 */
`timescale 1ns/100ps
module cmcp_bus_model (
    input wire logic ref_clk,
    input wire logic nrst,
    input wire logic holdBusy,
    input wire logic pulseGo,
    input wire logic [9:0] pulseLen,
    output logic busRx,
    output logic busIdle
);
    logic [9:0] domCnt_reg;
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            domCnt_reg <= 10'h000;
        end else if (pulseGo) begin
            domCnt_reg <= pulseLen;
        end else if (domCnt_reg != 10'h000) begin
            domCnt_reg <= domCnt_reg - 10'h001;
        end
    end
    // Released bus reads recessive, as the transceiver pulls it there
    assign busRx = (domCnt_reg == 10'h000);
    // Traffic or a pending frame keeps the node busy
    assign busIdle = !holdBusy && (domCnt_reg == 10'h000);
endmodule : cmcp_bus_model

// ---- bench/tb_can_mode_control_and_prescaler.sv ----
/*
 * Self-checking bench: AXI4-Lite master, mode handshakes, wake and divider.
 * Assumes cmcp_top and cmcp_pkg; the bus model stands on the far side.
 */
`timescale 1ns/100ps
module tb_can_mode_control_and_prescaler;
    import cmcp_pkg::*;
    logic ref_clk = 1'b0;
    logic nrst = 1'b0;
    logic specialMode = 1'b0;
    logic oscClkTick = 1'b0;
    logic txBitIn = 1'b1;
    logic userRecoverReq = 1'b0;
    logic holdBusy = 1'b0;
    logic pulseGo = 1'b0;
    logic [9:0] pulseLen = 10'h000;
    logic [5:0] awaddr = 6'h00;
    logic [5:0] araddr = 6'h00;
    logic [31:0] wdata = 32'h00000000;
    logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
    logic arvalid = 1'b0, rready = 1'b0;
    logic awready, wready, bvalid, arready, rvalid, busIdle, busRx;
    logic [1:0] bresp, rresp, oscCnt = 2'h0;
    logic [31:0] rdata;
    logic moduleEnable, tqTick, loopRxBit, ackErrDriveEn, errCntFreeze;
    logic txInhibit, recoverAllowed, protoAbort, wakeEvent;
    logic [2:0] resyncJumpQuanta;
    int errors = 0;
    int n_checks = 0;
    int wakeCount = 0;

    cmcp_top uut (.ref_clk(ref_clk), .nrst(nrst), .specialMode(specialMode),
        .oscClkTick(oscClkTick), .busIdle(busIdle), .busRx(busRx),
        .busOffState(1'b1), .userRecoverReq(userRecoverReq),
        .txBitIn(txBitIn),
        .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
        .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'h1),
        .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
        .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
        .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
        .s_axi_rvalid(rvalid), .s_axi_rready(rready),
        .moduleEnable(moduleEnable), .tqTick(tqTick),
        .resyncJumpQuanta(resyncJumpQuanta), .loopRxBit(loopRxBit),
        .ackErrDriveEn(ackErrDriveEn), .errCntFreeze(errCntFreeze),
        .txInhibit(txInhibit), .recoverAllowed(recoverAllowed),
        .protoAbort(protoAbort), .wakeEvent(wakeEvent));
    cmcp_bus_model bus (.ref_clk(ref_clk), .nrst(nrst), .holdBusy(holdBusy),
        .pulseGo(pulseGo), .pulseLen(pulseLen), .busRx(busRx),
        .busIdle(busIdle));

    always #5 ref_clk = ~ref_clk;
    // Oscillator tick every third cycle, so its divider differs from bus clock
    always @(posedge ref_clk) begin
        oscCnt <= (oscCnt == 2'h2) ? 2'h0 : oscCnt + 2'h1;
        oscClkTick <= (oscCnt == 2'h2);
    end
    // Wake pulses counted while they stand, one per bus wake from sleep
    always @(posedge ref_clk) begin
        if (wakeEvent === 1'b1) wakeCount <= wakeCount + 1;
    end

    task give_verdict;
        $display("Checks %0d mismatches %0d", n_checks, errors);
        if (errors == 0 && n_checks > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask : give_verdict

    task check(input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp) begin
            errors++;
            $display("ERROR t=%0t seen %h expected %h", $time, seen, exp);
        end
    endtask : check

    task axi_wr(input logic [5:0] a, input logic [7:0] d);
        @(posedge ref_clk);
        awaddr <= a;
        wdata <= {24'h000000, d};
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        do begin
            @(posedge ref_clk);
            if (awready === 1'b1) awvalid <= 1'b0;
            if (wready === 1'b1) wvalid <= 1'b0;
        end while (bvalid !== 1'b1);
        bready <= 1'b0;
        check({30'h0, bresp}, {30'h0, RESP_OKAY});
        // Settle time so registered outputs reflect the write
        repeat (2) @(posedge ref_clk);
    endtask : axi_wr

    // Bare read transfer; waits for the answer, the watchdog ends a hang
    task bus_rd(input logic [5:0] a);
        @(posedge ref_clk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do begin
            @(posedge ref_clk);
            if (arready === 1'b1) arvalid <= 1'b0;
        end while (rvalid !== 1'b1);
        rready <= 1'b0;
    endtask : bus_rd

    task axi_rd(input logic [5:0] a, input logic [31:0] exp,
                input logic [1:0] expResp);
        bus_rd(a);
        check(rdata, exp);
        check({30'h0, rresp}, {30'h0, expResp});
    endtask : axi_rd

    task rd(input logic [5:0] a, input logic [7:0] exp);
        axi_rd(a, {24'h000000, exp}, RESP_OKAY);
    endtask : rd

    task wait_mode(input logic [7:0] exp);
        int k;
        for (k = 0; k < 60; k++) begin
            bus_rd(ADDR_STATUS);
            if (rdata === {24'h000000, exp}) break;
        end
        check(rdata, {24'h000000, exp});
    endtask : wait_mode

    task tq_period(input int exp);
        int p;
        p = 0;
        while (tqTick !== 1'b1 && p < 500) begin
            @(posedge ref_clk);
            p++;
        end
        p = 0;
        do begin
            @(posedge ref_clk);
            p++;
        end while (tqTick !== 1'b1 && p < 500);
        check(p, exp);
    endtask : tq_period

    task dom_pulse(input logic [9:0] len);
        @(posedge ref_clk);
        pulseLen <= len;
        pulseGo <= 1'b1;
        @(posedge ref_clk);
        pulseGo <= 1'b0;
        repeat (len + 4) @(posedge ref_clk);
    endtask : dom_pulse

    task t_reset;
        rd(ADDR_CTL_ZERO, CTL_ZERO_RESET);
        rd(ADDR_CTL_ONE, CTL_ONE_RESET);
        rd(ADDR_BTR_ZERO, BTR_ZERO_RESET);
        axi_rd(6'h10, 32'h0, RESP_SLVERR);
        check(protoAbort, 1'b1);
        check(moduleEnable, 1'b0);
    endtask : t_reset

    task t_config;
        axi_wr(ADDR_CTL_ONE, 8'hF4);
        rd(ADDR_CTL_ONE, 8'hF5);
        axi_wr(ADDR_BTR_ZERO, 8'hC3);
        rd(ADDR_BTR_ZERO, 8'hC3);
        check(resyncJumpQuanta, 3'h4);
        check(moduleEnable, 1'b1);
        // Second enable write in normal operation must not clear it
        axi_wr(ADDR_CTL_ONE, 8'h74);
        rd(ADDR_CTL_ONE, 8'hF5);
        txBitIn <= 1'b0;
        repeat (3) @(posedge ref_clk);
        check(loopRxBit, 1'b0);
        txBitIn <= 1'b1;
        repeat (3) @(posedge ref_clk);
        check(loopRxBit, 1'b1);
    endtask : t_config

    task t_run;
        axi_wr(ADDR_CTL_ZERO, 8'h00);
        wait_mode(8'h01);
        rd(ADDR_CTL_ONE, 8'hF4);
        axi_wr(ADDR_CTL_ONE, 8'h00);
        rd(ADDR_CTL_ONE, 8'hF4);
        axi_wr(ADDR_BTR_ZERO, 8'h00);
        rd(ADDR_BTR_ZERO, 8'hC3);
        check(ackErrDriveEn, 1'b0);
        check(errCntFreeze, 1'b1);
        check(txInhibit, 1'b1);
        check(recoverAllowed, 1'b1);
        check(protoAbort, 1'b0);
        tq_period(4);
    endtask : t_run

    task t_sleep;
        holdBusy <= 1'b1;
        axi_wr(ADDR_CTL_ZERO, 8'h06);
        repeat (20) @(posedge ref_clk);
        rd(ADDR_STATUS, 8'h01);
        holdBusy <= 1'b0;
        wait_mode(8'h04);
        rd(ADDR_CTL_ONE, 8'hF6);
        // Glitch shorter than the filter time leaves the node asleep
        dom_pulse(10'd50);
        rd(ADDR_STATUS, 8'h04);
        check(wakeCount, 32'h0);
        dom_pulse(10'd250);
        check(wakeCount, 32'h1);
        rd(ADDR_CTL_ONE, 8'hF4);
        rd(ADDR_CTL_ZERO, 8'h04);
    endtask : t_sleep

    task t_nowake;
        axi_wr(ADDR_CTL_ZERO, 8'h02);
        wait_mode(8'h04);
        dom_pulse(10'd250);
        rd(ADDR_STATUS, 8'h04);
        check(wakeCount, 32'h1);
        axi_wr(ADDR_CTL_ZERO, 8'h00);
        rd(ADDR_CTL_ONE, 8'hF4);
    endtask : t_nowake

    task t_reinit;
        axi_wr(ADDR_CTL_ZERO, 8'h01);
        wait_mode(8'h02);
        check(protoAbort, 1'b1);
        check(txInhibit, 1'b1);
        specialMode <= 1'b1;
        axi_wr(ADDR_CTL_ONE, 8'h04);
        check(moduleEnable, 1'b0);
        axi_wr(ADDR_CTL_ONE, 8'h8C);
        check(recoverAllowed, 1'b0);
        userRecoverReq <= 1'b1;
        repeat (2) @(posedge ref_clk);
        check(recoverAllowed, 1'b1);
        userRecoverReq <= 1'b0;
        axi_wr(ADDR_BTR_ZERO, 8'h01);
        check(resyncJumpQuanta, 3'h1);
        axi_wr(ADDR_CTL_ZERO, 8'h00);
        wait_mode(8'h01);
        check(ackErrDriveEn, 1'b1);
        check(txInhibit, 1'b0);
        tq_period(6);
    endtask : t_reinit

    task t_fastwake;
        txBitIn <= 1'b0;
        axi_wr(ADDR_CTL_ZERO, 8'h01);
        wait_mode(8'h02);
        axi_wr(ADDR_CTL_ONE, 8'h80);
        axi_wr(ADDR_CTL_ZERO, 8'h06);
        wait_mode(8'h04);
        check(loopRxBit, 1'b1);
        // Unfiltered wake: a few dominant cycles are enough
        dom_pulse(10'd3);
        check(wakeCount, 32'h2);
        rd(ADDR_STATUS, 8'h01);
    endtask : t_fastwake

    initial begin
        repeat (4) @(posedge ref_clk);
        nrst <= 1'b1;
        t_reset();
        t_config();
        t_run();
        t_sleep();
        t_nowake();
        t_reinit();
        t_fastwake();
        give_verdict();
    end

    // Whole sequence needs under a thousand cycles; far beyond that is a hang
    initial begin
        repeat (20000) @(posedge ref_clk);
        errors++;
        give_verdict();
    end
endmodule : tb_can_mode_control_and_prescaler
